// *** erg_defines.svh ***
// Register indices, field positions, reset values and timing figures of the combo reset generator.
// Assumes inclusion by bare name from the package and the design module.
`ifndef ERG_DEFINES_SVH
`define ERG_DEFINES_SVH

// Register indices; the APB byte address is four times the index.
`define ERG_IDX_PRI_A 8'h38
`define ERG_IDX_PRI_B 8'h39
`define ERG_IDX_PRI_C 8'h3a
`define ERG_IDX_SEC_A 8'h3b
`define ERG_IDX_SEC_B 8'h3c
`define ERG_IDX_CFG 8'h3d
`define ERG_IDX_STATUS 8'h50

// Selector fields.
`define ERG_SEL_LEVEL 7
`define ERG_SEL_CODE_HI 6

// Configuration fields.
`define ERG_CFG_SEC_POL 7
`define ERG_CFG_PRI_POL 6
`define ERG_CFG_PIN_OVR 5
`define ERG_CFG_TRIG_HI 4
`define ERG_CFG_TRIG_LO 2
`define ERG_CFG_PW_HI 1
`define ERG_CFG_PW_LO 0

// Reset values of the writable registers.
`define ERG_SEL_RESET 8'h00
`define ERG_CFG_RESET 8'h00

// Codes up to this value are keys; higher codes are inputs and logic outputs.
`define ERG_KEY_CODE_MAX 7'h50

// Timing figures in their own units and the clock rate.
`define ERG_CLK_MHZ 100
`define ERG_TRIG_STEP_MS 500
`define ERG_PW0_US 500
`define ERG_PW1_MS 1
`define ERG_PW2_MS 2
`define ERG_PW3_MS 10

`endif

// *** erg_pkg.sv ***
// Types shared by the combo reset generator.
// Assumes the constants header is available by bare name.
`include "erg_defines.svh"

package erg_pkg;

  // Phase of one reset channel.
  typedef enum logic [1:0] {
    ERG_IDLE,
    ERG_HOLD,
    ERG_PULSE,
    ERG_WAIT
  } erg_phase_t;

  // State of one reset channel.
  typedef struct packed {
    erg_phase_t phase;
    logic [31:0] cnt;
  } erg_ch_t;

  // Whole state of the generator.
  typedef struct packed {
    logic [4:0][7:0] sel;
    logic [7:0] cfg;
    logic [31:0] prdata;
    erg_ch_t [1:0] ch;
    logic [1:0] pin_sync;
    logic out_pri;
    logic out_sec;
  } erg_state_t;

endpackage : erg_pkg

// *** erg_combo_reset.sv ***
// Combo reset generator: two reset outputs fired by held event combinations, set up over APB.
// Assumes event_active comes from pclk-domain scan logic and rst_pin_n from an asynchronous pin.
//
// How it works
// - Three level plus code selectors for primary.
// - Two level plus code selectors for secondary.
// - Selector with zero code is ignored.
// - All enabled selectors must match together.
// - Key selectors match only on press.
// - Input selectors match inactive or active state.
// - Config bit 7 sets secondary polarity.
// - Config bit 6 sets primary polarity.
// - Config bit 5 ORs pin into primary.
// - Pin never touches the secondary output.
// - Trigger field gives immediate or 1-4 s.
// - Shared trigger time, combo held throughout.
// - Pulse width field 500 us to 10 ms.
//
// Design decision made here: the APB register port.
`timescale 1ns/100ps
`include "erg_defines.svh"

module erg_combo_reset #(
  // Cycle counts are parameters so that a bench can shorten them.
  // Cycles per half-second trigger step.
  parameter logic [31:0] TRIG_STEP_CYC = `ERG_TRIG_STEP_MS * 1000 * `ERG_CLK_MHZ,
  // Cycles of each pulse width code.
  parameter logic [31:0] PW0_CYC = `ERG_PW0_US * `ERG_CLK_MHZ,
  parameter logic [31:0] PW1_CYC = `ERG_PW1_MS * 1000 * `ERG_CLK_MHZ,
  parameter logic [31:0] PW2_CYC = `ERG_PW2_MS * 1000 * `ERG_CLK_MHZ,
  parameter logic [31:0] PW3_CYC = `ERG_PW3_MS * 1000 * `ERG_CLK_MHZ
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [127:0] event_active,
  input wire logic rst_pin_n,
  output logic primary_reset_output,
  output logic secondary_reset_output
);

  // Registered state and its next value.
  // One packed struct holds every register of the block.
  erg_pkg::erg_state_t s;
  erg_pkg::erg_state_t next_s;

  // Per-selector enable and match.
  logic [4:0] sel_en;
  logic [4:0] sel_hit;
  // Combination met, per channel.
  logic [1:0] combo;
  // Hold and pulse lengths in cycles.
  logic [31:0] hold_cyc;
  logic [31:0] pw_cyc;
  // Decoded bus access.
  logic [7:0] idx;
  // True for the five selectors, the configuration and the status word.
  logic mapped;
  // Setup and access phases of the current transfer.
  logic setup;
  logic access;
  // Synchronised pin, active high.
  logic pin_act;
  // Reset request of each channel.
  logic act_pri;
  logic act_sec;

  // Per-selector match: code zero disables, keys match on press only.
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_sel
      // Code field and level qualifier of this selector.
      logic [6:0] code;
      logic lvl;
      logic is_key;
      assign code = s.sel[gi][`ERG_SEL_CODE_HI:0];
      assign lvl = s.sel[gi][`ERG_SEL_LEVEL];
      // Codes up to the key limit are keys, higher ones inputs or logic outputs.
      assign is_key = (code <= `ERG_KEY_CODE_MAX);
      assign sel_en[gi] = (code != 7'h00);
      assign sel_hit[gi] = is_key ? (lvl & event_active[code]) : (lvl == event_active[code]);
    end
  endgenerate

  // A channel with no selector enabled never fires.
  // all enabled selectors together.
  assign combo[0] = (|sel_en[2:0]) & (&(sel_hit[2:0] | ~sel_en[2:0]));
  assign combo[1] = (|sel_en[4:3]) & (&(sel_hit[4:3] | ~sel_en[4:3]));

  // Code zero is handled by the sequencer and never waits on this value.
  // trigger code n holds for n+1 half-second steps.
  assign hold_cyc = {29'h0, s.cfg[`ERG_CFG_TRIG_HI:`ERG_CFG_TRIG_LO]} * TRIG_STEP_CYC + TRIG_STEP_CYC;

  always_comb begin
    // Every code has a width; no value is reserved.
    case (s.cfg[`ERG_CFG_PW_HI:`ERG_CFG_PW_LO])
      2'h0: pw_cyc = PW0_CYC;
      2'h1: pw_cyc = PW1_CYC;
      2'h2: pw_cyc = PW2_CYC;
      default: pw_cyc = PW3_CYC;
    endcase
  end

  // Bus decode: word aligned addresses of the known registers only.
  // Word index from the byte address; the low two bits must be zero.
  assign idx = paddr[9:2];
  assign mapped = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0) &&
                  (((idx >= `ERG_IDX_PRI_A) && (idx <= `ERG_IDX_CFG)) || (idx == `ERG_IDX_STATUS));
  assign setup = psel & ~penable;
  assign access = psel & penable;

  // The slave always answers in the first access cycle.
  assign pready = 1'b1;
  // The error shows only in the access phase, so an idle bus never reports one.
  assign pslverr = access & ~mapped;
  // Read data comes straight from a flop and does not glitch during the access.
  assign prdata = s.prdata;

  // Only the second synchroniser stage is read.
  // The first stage may go metastable, so no logic looks at it.
  assign pin_act = ~s.pin_sync[1];

  // pin ORed into the primary request only.
  assign act_pri = (s.ch[0].phase == erg_pkg::ERG_PULSE) | (s.cfg[`ERG_CFG_PIN_OVR] & pin_act);
  assign act_sec = (s.ch[1].phase == erg_pkg::ERG_PULSE);

  // Next state: registers, read data, channel sequencers and outputs.
  always_comb begin
    // Everything holds unless a branch below says otherwise.
    next_s = s;
    // The pin shifts into the synchroniser on every edge.
    next_s.pin_sync = {s.pin_sync[0], rst_pin_n};
    // Read data is captured in the setup cycle, stable through the access.
    if (setup) begin
      // Unmapped addresses read as zero.
      next_s.prdata = 32'h0;
      if (mapped) begin
        if (idx == `ERG_IDX_STATUS) begin
          // Status: pin, both outputs and both phases.
          next_s.prdata[6:0] = {pin_act, s.out_sec, s.out_pri, s.ch[1].phase, s.ch[0].phase};
        end else if (idx == `ERG_IDX_CFG) begin
          // Configuration byte.
          next_s.prdata[7:0] = s.cfg;
        end else begin
          // One of the five selector bytes.
          next_s.prdata[7:0] = s.sel[idx - `ERG_IDX_PRI_A];
        end
      end
    end
    // selectors and config written in the access cycle.
    if (access && pwrite && mapped) begin
      if (idx == `ERG_IDX_CFG) begin
        // Configuration byte.
        next_s.cfg = pwdata[7:0];
      end else if (idx != `ERG_IDX_STATUS) begin
        // Selector bytes; the status word is read only.
        next_s.sel[idx - `ERG_IDX_PRI_A] = pwdata[7:0];
      end
    end
    // The two channels never interact; only the timing fields are shared.
    // Channel sequencers share the trigger time and pulse width.
    for (int c = 0; c < 2; c++) begin
      case (s.ch[c].phase)
        erg_pkg::ERG_IDLE: begin
          // Idle: wait for the combination with the count at zero.
          next_s.ch[c].cnt = 32'h0;
          if (combo[c]) begin
            if (s.cfg[`ERG_CFG_TRIG_HI:`ERG_CFG_TRIG_LO] == 3'h0) begin
              next_s.ch[c].phase = erg_pkg::ERG_PULSE;
            end else begin
              // Other codes start the hold timer.
              next_s.ch[c].phase = erg_pkg::ERG_HOLD;
            end
          end
        end
        erg_pkg::ERG_HOLD: begin
          // Hold: count while every enabled selector keeps matching.
          // broken combo restarts the timing.
          if (!combo[c]) begin
            next_s.ch[c].phase = erg_pkg::ERG_IDLE;
            next_s.ch[c].cnt = 32'h0;
          // fire once held the whole time.
          end else if (s.ch[c].cnt >= hold_cyc - 32'h1) begin
            next_s.ch[c].phase = erg_pkg::ERG_PULSE;
            next_s.ch[c].cnt = 32'h0;
          end else begin
            // Still held: keep counting.
            next_s.ch[c].cnt = s.ch[c].cnt + 32'h1;
          end
        end
        erg_pkg::ERG_PULSE: begin
          // Pulse: the output is active for the programmed width.
          // pulse lasts the programmed width.
          if (s.ch[c].cnt >= pw_cyc - 32'h1) begin
            next_s.ch[c].phase = erg_pkg::ERG_WAIT;
            next_s.ch[c].cnt = 32'h0;
          end else begin
            // Keep the pulse going.
            next_s.ch[c].cnt = s.ch[c].cnt + 32'h1;
          end
        end
        erg_pkg::ERG_WAIT: begin
          // Wait: one held combination fires only once.
          // rearm only after release.
          if (!combo[c]) begin
            next_s.ch[c].phase = erg_pkg::ERG_IDLE;
          end
        end
        default: begin
          // An unknown phase falls back to idle.
          next_s.ch[c].phase = erg_pkg::ERG_IDLE;
          next_s.ch[c].cnt = 32'h0;
        end
      endcase
    end
    // Outputs are registered so the host never sees decode glitches.
    // primary polarity.
    next_s.out_pri = s.cfg[`ERG_CFG_PRI_POL] ? act_pri : ~act_pri;
    next_s.out_sec = s.cfg[`ERG_CFG_SEC_POL] ? act_sec : ~act_sec;
  end

  // State register; outputs idle high since reset polarity is active low.
  always_ff @(posedge pclk or negedge presetn) begin
    // Asynchronous reset loads constants only.
    if (!presetn) begin
      s.sel <= {5{`ERG_SEL_RESET}};
      s.cfg <= `ERG_CFG_RESET;
      s.prdata <= 32'h0;
      s.ch <= '0;
      s.pin_sync <= 2'h3;
      s.out_pri <= 1'b1;
      s.out_sec <= 1'b1;
    end else begin
      // Every register takes its next value on every edge.
      s <= next_s;
    end
  end

  // The state flops drive the output pins directly.
  assign primary_reset_output = s.out_pri;
  assign secondary_reset_output = s.out_sec;

  // Checks of the sequencers, outputs and register writes.
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Every check runs on pclk and stays silent while reset is applied.

  // Register writes land in the selector they address.
  a_sel_write: assert property (access && pwrite && idx == `ERG_IDX_PRI_B && paddr[1:0] == 2'h0
    && paddr[11:10] == 2'h0 |=> s.sel[1] == $past(pwdata[7:0])) else $error("selector write lost");
  a_sec_sel_write: assert property (access && pwrite && paddr == 12'h0f0
    |=> s.sel[4] == $past(pwdata[7:0])) else $error("secondary selector write lost");
  // Selector decode and combination.
  a_zero_ignored: assert property (s.ch[0].phase == erg_pkg::ERG_IDLE && sel_en[2:0] == 3'h0
    |=> s.ch[0].phase == erg_pkg::ERG_IDLE) else $error("zero selectors armed primary");
  a_combo_needed: assert property (s.ch[1].phase == erg_pkg::ERG_IDLE && !combo[1]
    |=> s.ch[1].phase == erg_pkg::ERG_IDLE) else $error("secondary left idle without combo");
  a_key_release: assert property (sel_en[0] && s.sel[0][6:0] <= `ERG_KEY_CODE_MAX
    && !s.sel[0][7] |-> !sel_hit[0]) else $error("key release matched");
  a_input_level: assert property (sel_en[3] && s.sel[3][6:0] > `ERG_KEY_CODE_MAX
    |-> sel_hit[3] == (s.sel[3][7] == event_active[s.sel[3][6:0]])) else $error("input level wrong");
  // Output polarity and the pin path.
  a_sec_polarity: assert property (##1 secondary_reset_output == ($past(s.cfg[7])
    ? ($past(s.ch[1].phase) == erg_pkg::ERG_PULSE) : ($past(s.ch[1].phase) != erg_pkg::ERG_PULSE)))
    else $error("secondary polarity wrong");
  a_pri_override: assert property (s.cfg[6:5] == 2'h3 && pin_act |=> primary_reset_output)
    else $error("pin did not force primary");
  a_pri_polarity: assert property (!s.cfg[5] |=> primary_reset_output == ($past(s.cfg[6])
    ? ($past(s.ch[0].phase) == erg_pkg::ERG_PULSE) : ($past(s.ch[0].phase) != erg_pkg::ERG_PULSE)))
    else $error("primary polarity wrong");
  a_sec_pin_free: assert property (pin_act && s.ch[1].phase != erg_pkg::ERG_PULSE
    |=> secondary_reset_output == ~$past(s.cfg[7])) else $error("pin reached secondary");
  // Sequencer timing.
  a_immediate: assert property (s.ch[0].phase == erg_pkg::ERG_IDLE && combo[0]
    && s.cfg[4:2] == 3'h0 |=> s.ch[0].phase == erg_pkg::ERG_PULSE) else $error("immediate fire missed");
  a_hold_early: assert property (s.ch[0].phase == erg_pkg::ERG_HOLD && s.ch[0].cnt + 32'h1 < hold_cyc
    |=> s.ch[0].phase != erg_pkg::ERG_PULSE) else $error("fired before trigger time");
  a_pulse_width: assert property (s.ch[1].phase == erg_pkg::ERG_PULSE && s.ch[1].cnt + 32'h1 < pw_cyc
    |=> s.ch[1].phase == erg_pkg::ERG_PULSE) else $error("pulse ended early");
  a_hold_abort: assert property (s.ch[0].phase == erg_pkg::ERG_HOLD && !combo[0]
    |=> s.ch[0].phase == erg_pkg::ERG_IDLE && s.ch[0].cnt == 32'h0) else $error("abort missed");
  a_rearm_wait: assert property (s.ch[1].phase == erg_pkg::ERG_WAIT && combo[1]
    |=> s.ch[1].phase == erg_pkg::ERG_WAIT) else $error("rearmed without release");

  // Main scenarios: timed fire, pulse end, pin path, bus error and a broken hold.
  c_pri_fire: cover property (s.ch[0].phase == erg_pkg::ERG_HOLD ##1 s.ch[0].phase == erg_pkg::ERG_PULSE);
  c_sec_fire: cover property (s.ch[1].phase == erg_pkg::ERG_PULSE ##1 s.ch[1].phase == erg_pkg::ERG_WAIT);
  c_pin_pass: cover property (s.cfg[5] && pin_act);
  c_bus_error: cover property (pslverr);
  c_hold_abort: cover property (s.ch[0].phase == erg_pkg::ERG_HOLD ##1 s.ch[0].phase == erg_pkg::ERG_IDLE);

endmodule : erg_combo_reset

// *** erg_host_model.sv ***
// Host-side model that watches one reset line and logs its pulses.
// Assumes the line rests at the level opposite to act_high.
`timescale 1ns/100ps

module erg_host_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic line,
  input wire logic act_high,
  output logic [15:0] width,
  output logic [15:0] pulses
);
  logic [15:0] run; // Active cycles seen so far.

  // The host counts active cycles and logs a pulse when it ends.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run <= 16'h0;
      width <= 16'h0;
      pulses <= 16'h0;
    end else if (line === act_high) begin
      run <= run + 16'h1;
    end else if (run != 16'h0) begin
      width <= run;
      pulses <= pulses + 16'h1;
      run <= 16'h0;
    end
  end
endmodule : erg_host_model

// *** erg_combo_reset_tb.sv ***
// Self-checking bench for the combo reset generator.
// Assumes the design, its package and the host model are compiled first.
`timescale 1ns/100ps

module erg_combo_reset_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, pri_out, sec_out, er;
  logic [127:0] ev = '0, off_ev = '0; // Event levels, held and released.
  logic pin_n = 1'b1; // External pin, idle high.
  logic pol_p = 1'b0, pol_s = 1'b0; // Active levels the host expects.
  logic [15:0] wid_p, wid_s, cnt_p, cnt_s;
  logic [15:0] pw [4] = '{16'h4, 16'h6, 16'h8, 16'ha}; // Short pulse widths.
  int bad_count = 0, comparisons = 0;

  always #5 pclk = ~pclk;

  // Shortened counts keep every timing test within a few hundred cycles.
  erg_combo_reset #(.TRIG_STEP_CYC(32'h14), .PW0_CYC(32'h4), .PW1_CYC(32'h6), .PW2_CYC(32'h8),
    .PW3_CYC(32'ha)) i_erg_combo_reset (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .event_active(ev), .rst_pin_n(pin_n),
    .primary_reset_output(pri_out), .secondary_reset_output(sec_out));
  erg_host_model i_erg_host_model_pri (.pclk(pclk), .presetn(presetn), .line(pri_out),
    .act_high(pol_p), .width(wid_p), .pulses(cnt_p));
  erg_host_model i_erg_host_model_sec (.pclk(pclk), .presetn(presetn), .line(sec_out),
    .act_high(pol_s), .width(wid_s), .pulses(cnt_s));

  // Compares one value and logs a mismatch.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; waits for pready and leaves one idle cycle after it.
  task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // Programs all five selectors and the configuration.
  task automatic setup(input logic [7:0] c, pa, pb, pc, sa, sb);
    apb(12'h0e0, 1'b1, pa);
    apb(12'h0e4, 1'b1, pb);
    apb(12'h0e8, 1'b1, pc);
    apb(12'h0ec, 1'b1, sa);
    apb(12'h0f0, 1'b1, sb);
    apb(12'h0f4, 1'b1, c);
    repeat (4) @(posedge pclk);
  endtask : setup

  // Holds a combination, releases it and judges the pulses seen.
  task automatic pulse(input logic [127:0] on, input int cyc, input logic [15:0] np, ns, w);
    logic [15:0] p0, s0;
    p0 = cnt_p;
    s0 = cnt_s;
    ev <= on;
    repeat (cyc) @(posedge pclk);
    ev <= off_ev;
    repeat (30) @(posedge pclk);
    chk(32'(cnt_p - p0), 32'(np));
    chk(32'(cnt_s - s0), 32'(ns));
    if (np != 16'h0) chk(32'(wid_p), 32'(w));
    if (ns != 16'h0) chk(32'(wid_s), 32'(w));
  endtask : pulse

  // Reset values, read-back and a refused address.
  task automatic t_regs();
    apb(12'h140, 1'b0, 8'h00);
    chk(rd, 32'h30);
    for (int i = 0; i < 6; i++) begin
      apb(12'h0e0 + 12'(4 * i), 1'b0, 8'h00);
      chk(rd, 32'h0);
      apb(12'h0e0 + 12'(4 * i), 1'b1, 8'h5a + 8'(i));
      apb(12'h0e0 + 12'(4 * i), 1'b0, 8'h00);
      chk(rd, 32'h5a + 32'(i));
    end
    apb(12'h0dc, 1'b1, 8'hff);
    chk({31'h0, er}, 32'h1);
    $display("test regs done");
  endtask : t_regs

  // Key and input combinations on the primary output.
  task automatic t_combo();
    setup(8'h00, 8'h85, 8'h86, 8'h00, 8'h00, 8'h00);
    chk({31'h0, pri_out}, 32'h1);
    pulse(128'h20, 20, 16'h0, 16'h0, 16'h0);
    pulse(128'h60, 20, 16'h1, 16'h0, pw[0]);
    setup(8'h00, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00);
    pulse(128'h20, 20, 16'h0, 16'h0, 16'h0);
    ev <= 128'h1 << 81;
    off_ev <= 128'h1 << 81;
    setup(8'h00, 8'h51, 8'h00, 8'h00, 8'h00, 8'h00);
    pulse(128'h0, 20, 16'h1, 16'h0, pw[0]);
    off_ev <= '0;
    ev <= '0;
    setup(8'h00, 8'hd1, 8'h00, 8'h00, 8'h00, 8'h00);
    pulse(128'h1 << 81, 20, 16'h1, 16'h0, pw[0]);
    $display("test combo done");
  endtask : t_combo

  // Every pulse width on an active-high secondary output.
  task automatic t_widths();
    for (int c = 0; c < 4; c++) begin
      setup(8'h80 | 8'(c), 8'h00, 8'h00, 8'h00, 8'h87, 8'h00);
      pol_s <= 1'b1;
      // Two edges let the host log the level change before the counts are taken.
      repeat (2) @(posedge pclk);
      pulse(128'h80, 20, 16'h0, 16'h1, pw[c]);
    end
    chk({31'h0, sec_out}, 32'h0);
    $display("test widths done");
  endtask : t_widths

  // Trigger hold times, broken holds and restart.
  task automatic t_trig();
    int h;
    for (int c = 1; c < 8; c += 6) begin
      h = (c + 1) * 20;
      setup({3'b100, 3'(c), 2'b00}, 8'h85, 8'h00, 8'h00, 8'h85, 8'h00);
      pulse(128'h20, h - 5, 16'h0, 16'h0, 16'h0);
      pulse(128'h20, h - 5, 16'h0, 16'h0, 16'h0);
      pulse(128'h20, h + 5, 16'h1, 16'h1, pw[0]);
    end
    $display("test trigger done");
  endtask : t_trig

  // The pin reaches the primary output only while the override is set.
  task automatic t_pin();
    logic [15:0] p0, s0;
    for (int k = 0; k < 2; k++) begin
      setup(k == 0 ? 8'he0 : 8'hc0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
      pol_p <= 1'b1;
      repeat (4) @(posedge pclk);
      p0 = cnt_p;
      s0 = cnt_s;
      pin_n <= 1'b0;
      repeat (10) @(posedge pclk);
      pin_n <= 1'b1;
      repeat (30) @(posedge pclk);
      chk(32'(cnt_p - p0), k == 0 ? 32'h1 : 32'h0);
      chk(32'(cnt_s - s0), 32'h0);
      if (k == 0) chk(32'(wid_p), 32'ha);
    end
    $display("test pin done");
  endtask : t_pin

  // Prints the counts and the verdict, then stops.
  task automatic complete_run();
    $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run

  // Main sequence after a 20-cycle reset.
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_combo();
    t_widths();
    t_trig();
    t_pin();
    complete_run();
  end

  // The tests need some 1700 cycles; this limit leaves a wide margin.
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    complete_run();
  end
endmodule : erg_combo_reset_tb
